// >>> verilog/rtcs_scheduler.sv
// Real-time clock with a 21-entry time-of-day event scheduler, APB slave.
// Assumes synchronous inputs on clk_sys; APB answers with no wait states.
`timescale 1ns/1ps
module rtcs_scheduler
   import rtcs_pkg::*;
#(
   parameter int unsigned MINUTE_CYCLES = MINUTE_CYC
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Selections and start requests from inputs and bus
   input wire logic [1:0] ext_setup,
   input wire logic [1:0] ext_preset,
   input wire logic di_start,
   input wire logic bus_start,
   // Drive commands
   output logic [1:0] setup_sel,
   output logic [1:0] preset_sel,
   output logic analog_output_a,
   output logic analog_output_b,
   output logic relay_1,
   output logic relay_2,
   output logic run_cmd
);
   rtcs_cal_if cal_if ();
   rtcs_state_t state;
   logic [3:0] ev_day [EVENT_COUNT];
   logic [10:0] now, ev_on [EVENT_COUNT], ev_off [EVENT_COUNT];
   logic [4:0] ev_on_act [EVENT_COUNT], ev_off_act [EVENT_COUNT];
   logic [EVENT_COUNT-1:0] on_hit, off_hit, passed, pend_on, pend_off;
   logic [1:0] ctrl, sched_setup, sched_preset;
   logic [4:0] idx, cur_act, ev_idx;
   logic wr, rd, ev_sel, ev_word, mapped, phase, sched_run;
   logic load_d, startup_pending, sched_setup_valid, sched_preset_valid;
   logic [31:0] next_rdata;

   rtcs_calendar #(.MINUTE_CYCLES(MINUTE_CYCLES)) rtcs_calendar_inst (
      .clk_sys(clk_sys), .rst(rst), .cal(cal_if.cal));

   function automatic logic day_match(input logic [3:0] sel,
      input logic [2:0] wd);
      case (sel)
         DAY_ANY: day_match = 1'b1;
         DAY_MON_FRI: day_match = wd <= 3'd5;
         DAY_SAT_SUN: day_match = wd >= 3'd6;
         DAY_MON_THU: day_match = wd <= 3'd4;
         DAY_FRI_SUN: day_match = wd >= 3'd5;
         DAY_SUN_FRI: day_match = wd != 3'd6;
         default: day_match = sel != DAY_OFF && sel[2:0] == wd;
      endcase
   endfunction : day_match

   function automatic logic [2:0] act_group(input logic [4:0] act);
      act_group = (act == ACT_NONE) ? 3'd0 : 3'((act - 5'd1) >> 2) + 3'd1;
   endfunction : act_group

   // APB decode; event words sit at 0x100 + 8 * index, two words each.
   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;
   assign ev_idx = paddr[7:3];
   assign ev_word = paddr[2];
   assign ev_sel = paddr[11:8] == OFS_EVENT_PAGE && paddr[1:0] == 2'h0
      && ev_idx < 5'(EVENT_COUNT);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign now = {cal_if.hh, cal_if.mi};
   assign cal_if.load_time = wr && paddr == OFS_DATETIME;
   assign cal_if.load_wday = wr && paddr == OFS_WEEKDAY;
   assign cal_if.ld_word = pwdata;
   assign cal_if.ld_wday = pwdata[2:0];

   always_comb
   begin
      mapped = 1'b1;
      next_rdata = '0;
      if (ev_sel && !ev_word)
         next_rdata = {4'h0, ev_day[ev_idx], 3'h0, ev_on[ev_idx][10:6],
            2'h0, ev_on[ev_idx][5:0], 3'h0, ev_on_act[ev_idx]};
      else if (ev_sel)
         next_rdata = {11'h0, ev_off[ev_idx][10:6], 2'h0,
            ev_off[ev_idx][5:0], 3'h0, ev_off_act[ev_idx]};
      else
         case (paddr)
            OFS_DATETIME: next_rdata = {cal_if.yy, cal_if.mo[3:0],
               cal_if.dd, 3'h0, cal_if.hh, 2'h0, cal_if.mi};
            OFS_WEEKDAY: next_rdata = {29'h0, cal_if.wday};
            OFS_CTRL: next_rdata = {30'h0, ctrl};
            OFS_STATUS: next_rdata = {22'h0, run_cmd, relay_2, relay_1,
               analog_output_b, analog_output_a, preset_sel, setup_sel,
               state == ST_SCAN};
            default: mapped = 1'b0;
         endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         prdata <= '0;
      else if (rd && !penable)
         prdata <= next_rdata;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ctrl <= CTRL_RST;
      else if (wr && paddr == OFS_CTRL)
         ctrl <= pwdata[1:0];
   end

   // Table writes; a field wider than its range is taken as written.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         for (int i = 0; i < EVENT_COUNT; i++)
         begin
            ev_day[i] <= DAY_OFF;
            ev_on[i] <= '0;
            ev_on_act[i] <= ACT_NONE;
            ev_off[i] <= '0;
            ev_off_act[i] <= ACT_NONE;
         end
      else if (wr && ev_sel && !ev_word)
      begin
         ev_day[ev_idx] <= pwdata[EV_DAY_LSB +: 4];
         ev_on[ev_idx] <= {pwdata[EV_TIME_LSB+8 +: 5],
            pwdata[EV_TIME_LSB +: 6]};
         ev_on_act[ev_idx] <= pwdata[EV_ACT_LSB +: 5];
      end
      else if (wr && ev_sel)
      begin
         ev_off[ev_idx] <= {pwdata[EV_TIME_LSB+8 +: 5],
            pwdata[EV_TIME_LSB +: 6]};
         ev_off_act[ev_idx] <= pwdata[EV_ACT_LSB +: 5];
      end
   end

   // Each event is judged on its own, so periods may overlap.
   for (genvar g = 0; g < EVENT_COUNT; g++)
   begin : g_event
      logic dm;
      assign dm = day_match(ev_day[g], cal_if.wday);
      assign on_hit[g] = dm && ev_on[g] == now;
      assign off_hit[g] = ev_day[g] != DAY_OFF && ev_off[g] == now;
      assign passed[g] = dm && ev_on[g] <= now
         && (ev_off[g] > now || ev_off[g] < ev_on[g]);
   end

   // The catch-up runs at most once: on the first time load after reset, if the wait bit is clear.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         load_d <= 1'b0;
         startup_pending <= 1'b1;
      end
      else
      begin
         load_d <= cal_if.load_time;
         if (load_d)
            startup_pending <= 1'b0;
      end
   end

   // One action per cycle: OFF of an event, then its ON, index upward.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         idx <= '0;
         phase <= 1'b0;
         pend_on <= '0;
         pend_off <= '0;
      end
      else
         case (state)
            ST_IDLE:
               if (cal_if.tick || (load_d && startup_pending
                  && !ctrl[CTRL_WAIT_BIT]))
               begin
                  pend_on <= cal_if.tick ? on_hit : passed;
                  pend_off <= cal_if.tick ? off_hit : '0;
                  idx <= '0;
                  phase <= 1'b0;
                  state <= ST_SCAN;
               end
            ST_SCAN:
            begin
               phase <= !phase;
               if (phase && idx == 5'(EVENT_COUNT - 1))
                  state <= ST_IDLE;
               else if (phase)
                  idx <= idx + 5'd1;
            end
            default: state <= ST_IDLE;
         endcase
   end

   always_comb
   begin
      cur_act = ACT_NONE;
      if (state == ST_SCAN && phase && pend_on[idx])
         cur_act = ev_on_act[idx];
      else if (state == ST_SCAN && !phase && pend_off[idx]
         && act_group(ev_off_act[idx]) == act_group(ev_on_act[idx]))
         cur_act = ev_off_act[idx];
   end

   // Scheduler's own selections; each holds until another action of its own kind.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sched_setup_valid <= 1'b0;
         sched_setup <= '0;
         sched_preset_valid <= 1'b0;
         sched_preset <= '0;
      end
      else if (cur_act != ACT_NONE && cur_act <= 5'd4)
      begin
         sched_setup_valid <= 1'b1;
         sched_setup <= 2'(cur_act - 5'd1);
      end
      else if (cur_act > 5'd4 && cur_act < ACT_AO_A_OFF)
      begin
         sched_preset_valid <= 1'b1;
         sched_preset <= 2'(cur_act - 5'd5);
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         analog_output_a <= 1'b0;
         analog_output_b <= 1'b0;
         relay_1 <= 1'b0;
         relay_2 <= 1'b0;
      end
      else
         case (cur_act)
            ACT_AO_A_OFF: analog_output_a <= 1'b0;
            ACT_AO_A_ON: analog_output_a <= 1'b1;
            ACT_AO_B_OFF: analog_output_b <= 1'b0;
            ACT_AO_B_ON: analog_output_b <= 1'b1;
            ACT_RLY1_ON: relay_1 <= 1'b1;
            ACT_RLY1_OFF: relay_1 <= 1'b0;
            ACT_RLY2_ON: relay_2 <= 1'b1;
            ACT_RLY2_OFF: relay_2 <= 1'b0;
            default: ;
         endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         sched_run <= 1'b0;
      else if (cur_act == ACT_START)
         sched_run <= 1'b1;
      else if (cur_act == ACT_STOP)
         sched_run <= 1'b0;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         setup_sel <= '0;
         preset_sel <= '0;
         run_cmd <= 1'b0;
      end
      else
      begin
         setup_sel <= sched_setup_valid ? sched_setup : ext_setup;
         preset_sel <= sched_preset_valid ? sched_preset
            : ext_preset;
         run_cmd <= ctrl[CTRL_AND_BIT] ? sched_run && di_start && bus_start
            : sched_run || di_start || bus_start;
      end
   end

   a_scan_length: assert property (@(posedge clk_sys) disable iff (rst)
      state == ST_IDLE ##1 state == ST_SCAN |-> ##41 state == ST_SCAN
      ##1 state == ST_IDLE) else $error("scan length wrong");
   a_setup_prio: assert property (@(posedge clk_sys) disable iff (rst)
      sched_setup_valid |=> setup_sel == $past(sched_setup))
      else $error("setup override lost");
   a_preset_prio: assert property (@(posedge clk_sys) disable iff (rst)
      sched_preset_valid |=> preset_sel == $past(sched_preset))
      else $error("preset override lost");
   a_off_group: assert property (@(posedge clk_sys) disable iff (rst)
      state == ST_SCAN && !phase && cur_act != ACT_NONE |->
      act_group(cur_act) == act_group(ev_on_act[idx]))
      else $error("unrelated off action run");
   a_ao_switch: assert property (@(posedge clk_sys) disable iff (rst)
      cur_act == ACT_AO_A_ON |=> analog_output_a)
      else $error("analog output a not switched on");
   a_stop_only: assert property (@(posedge clk_sys) disable iff (rst)
      cur_act == ACT_STOP |=> !sched_run && $stable(relay_1)
      && $stable(analog_output_a)) else $error("stop had side effect");
   a_run_and: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl[CTRL_AND_BIT] && !sched_run |=> !run_cmd)
      else $error("and combine ignored");
   a_wait_startup: assert property (@(posedge clk_sys) disable iff (rst)
      load_d && ctrl[CTRL_WAIT_BIT] && state == ST_IDLE && !cal_if.tick
      |=> state == ST_IDLE) else $error("catch-up in wait mode");
endmodule : rtcs_scheduler

// >>> verilog/rtcs_pkg.sv
// Constants shared by the real-time clock event scheduler.
// Assumes a 10 MHz system clock and an APB slave with 32-bit data.
package rtcs_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned MINUTE_S = 60;
   localparam int unsigned MINUTE_CYC = MINUTE_S * CLK_HZ;
   localparam int unsigned EVENT_COUNT = 21;

   // Register byte offsets.
   localparam logic [11:0] OFS_DATETIME = 12'h000;
   localparam logic [11:0] OFS_WEEKDAY = 12'h004;
   localparam logic [11:0] OFS_CTRL = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00c;
   localparam logic [3:0] OFS_EVENT_PAGE = 4'h1;

   // Date-time word fields: year, month, day, hours, minutes.
   localparam int unsigned DT_YY_LSB = 25;
   localparam int unsigned DT_MO_LSB = 21;
   localparam int unsigned DT_DD_LSB = 16;
   localparam int unsigned DT_HH_LSB = 8;
   localparam int unsigned DT_MI_LSB = 0;
   // Event words: day selector, time of day and action code.
   localparam int unsigned EV_DAY_LSB = 24;
   localparam int unsigned EV_TIME_LSB = 8;
   localparam int unsigned EV_ACT_LSB = 0;
   // Control bits.
   localparam int unsigned CTRL_WAIT_BIT = 0;
   localparam int unsigned CTRL_AND_BIT = 1;

   // Reset values.
   localparam logic [2:0] WDAY_RST = 3'h1;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam logic [4:0] MO_RST = 5'h01;
   localparam logic [4:0] DD_RST = 5'h01;

   // Day selector codes.
   localparam logic [3:0] DAY_OFF = 4'h0;
   localparam logic [3:0] DAY_ANY = 4'h8;
   localparam logic [3:0] DAY_MON_FRI = 4'h9;
   localparam logic [3:0] DAY_SAT_SUN = 4'ha;
   localparam logic [3:0] DAY_MON_THU = 4'hb;
   localparam logic [3:0] DAY_FRI_SUN = 4'hc;
   localparam logic [3:0] DAY_SUN_FRI = 4'hd;

   // Action codes.
   localparam logic [4:0] ACT_NONE = 5'h00;
   localparam logic [4:0] ACT_AO_A_OFF = 5'h09;
   localparam logic [4:0] ACT_AO_A_ON = 5'h0a;
   localparam logic [4:0] ACT_AO_B_OFF = 5'h0b;
   localparam logic [4:0] ACT_AO_B_ON = 5'h0c;
   localparam logic [4:0] ACT_RLY1_ON = 5'h0d;
   localparam logic [4:0] ACT_RLY1_OFF = 5'h0e;
   localparam logic [4:0] ACT_RLY2_ON = 5'h0f;
   localparam logic [4:0] ACT_RLY2_OFF = 5'h10;
   localparam logic [4:0] ACT_START = 5'h11;
   localparam logic [4:0] ACT_STOP = 5'h12;

   typedef enum logic [1:0] {ST_IDLE, ST_SCAN} rtcs_state_t;
endpackage : rtcs_pkg

// >>> verilog/rtcs_cal_if.sv
// Link between the register front end and the calendar counter.
// Both ends run on clk_sys.
`timescale 1ns/1ps
interface rtcs_cal_if;
   logic load_time;
   logic load_wday;
   logic [31:0] ld_word;
   logic [2:0] ld_wday;
   logic [6:0] yy;
   logic [4:0] mo;
   logic [4:0] dd;
   logic [4:0] hh;
   logic [5:0] mi;
   logic [2:0] wday;
   logic tick;
   modport ctl (output load_time, load_wday, ld_word, ld_wday,
      input yy, mo, dd, hh, mi, wday, tick);
   modport cal (input load_time, load_wday, ld_word, ld_wday,
      output yy, mo, dd, hh, mi, wday, tick);
endinterface : rtcs_cal_if

// >>> verilog/rtcs_calendar.sv
// Minute prescaler, date and time of day, and weekday counter.
// Assumes loaded values are in range; the weekday is never derived.
`timescale 1ns/1ps
module rtcs_calendar
   import rtcs_pkg::*;
#(
   parameter int unsigned MINUTE_CYCLES = MINUTE_CYC
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Front end
   rtcs_cal_if.cal cal
);
   localparam logic [29:0] PRESC_MAX = 30'(MINUTE_CYCLES - 1);
   logic [29:0] presc;
   logic wrap;
   logic [4:0] month_days;
   logic end_hour;
   logic end_day;
   logic end_month;

   assign wrap = (presc == PRESC_MAX) && !cal.load_time;
   assign end_hour = cal.mi == 6'd59;
   assign end_day = end_hour && cal.hh == 5'd23;
   assign end_month = end_day && cal.dd == month_days;

   always_comb
   begin
      case (cal.mo)
         5'd4, 5'd6, 5'd9, 5'd11: month_days = 5'd30;
         5'd2: month_days = (cal.yy[1:0] == 2'h0) ? 5'd29 : 5'd28;
         default: month_days = 5'd31;
      endcase
   end

   // Writing the time restarts the minute, so counting starts from it.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         presc <= '0;
      else if (cal.load_time || presc == PRESC_MAX)
         presc <= '0;
      else
         presc <= presc + 30'd1;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         cal.tick <= 1'b0;
      else
         cal.tick <= wrap;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cal.yy <= '0;
         cal.mo <= MO_RST;
         cal.dd <= DD_RST;
         cal.hh <= '0;
         cal.mi <= '0;
      end
      else if (cal.load_time)
      begin
         cal.yy <= cal.ld_word[DT_YY_LSB +: 7];
         cal.mo <= {1'b0, cal.ld_word[DT_MO_LSB +: 4]};
         cal.dd <= cal.ld_word[DT_DD_LSB +: 5];
         cal.hh <= cal.ld_word[DT_HH_LSB +: 5];
         cal.mi <= cal.ld_word[DT_MI_LSB +: 6];
      end
      else if (wrap)
      begin
         cal.mi <= end_hour ? 6'd0 : cal.mi + 6'd1;
         if (end_hour)
            cal.hh <= end_day ? 5'd0 : cal.hh + 5'd1;
         if (end_day)
            cal.dd <= end_month ? DD_RST : cal.dd + 5'd1;
         if (end_month)
            cal.mo <= (cal.mo == 5'd12) ? MO_RST : cal.mo + 5'd1;
         if (end_month && cal.mo == 5'd12)
            cal.yy <= (cal.yy == 7'd99) ? 7'd0 : cal.yy + 7'd1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         cal.wday <= WDAY_RST;
      else if (cal.load_wday)
         cal.wday <= cal.ld_wday;
      else if (wrap && end_day)
         cal.wday <= (cal.wday == 3'd7) ? 3'd1 : cal.wday + 3'd1;
   end

   a_midnight_roll: assert property (@(posedge clk_sys) disable iff (rst)
      wrap && end_day |=> cal.hh == 5'd0 && cal.mi == 6'd0 && cal.tick)
      else $error("time did not roll over at midnight");
   a_time_load: assert property (@(posedge clk_sys) disable iff (rst)
      cal.load_time |=> cal.mi == $past(cal.ld_word[5:0]) && !cal.tick)
      else $error("loaded minutes not taken");
   a_weekday_range: assert property (@(posedge clk_sys) disable iff (rst)
      cal.wday != 3'd0) else $error("weekday out of range");
endmodule : rtcs_calendar

// >>> verification/rtcs_drive_model.sv
// Model of the drive control side that feeds selections and starts.
// Assumes the bench changes start_req just after a clk_sys edge.
`timescale 1ns/1ps
module rtcs_drive_model
   import rtcs_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Bench control
   input wire logic [1:0] start_req,
   // Selections and starts toward the scheduler
   output logic [1:0] ext_setup,
   output logic [1:0] ext_preset,
   output logic di_start,
   output logic bus_start
);
   // Fixed nonzero selections make a scheduler override visible.
   assign ext_setup = 2'h3;
   assign ext_preset = 2'h2;
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         di_start <= 1'b0;
         bus_start <= 1'b0;
      end
      else
      begin
         di_start <= start_req[0];
         bus_start <= start_req[1];
      end
   end
endmodule : rtcs_drive_model

// >>> verification/rtcs_scheduler_tb.sv
// Self-checking bench for the event scheduler, driven over APB.
// Assumes MINUTE_CYCLES of 100, so one scan ends before the next tick.
`timescale 1ns/1ps
module rtcs_scheduler_tb
   import rtcs_pkg::*;
;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [1:0] ext_setup, ext_preset, setup_sel, preset_sel, start_req;
   logic di_start, bus_start, ao_a, ao_b, relay_1, relay_2, run_cmd;
   logic [8:0] es;
   int err_count, n_tests;

   rtcs_scheduler #(.MINUTE_CYCLES(100)) rtcs_scheduler_inst (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_setup(ext_setup),
      .ext_preset(ext_preset), .di_start(di_start),
      .bus_start(bus_start), .setup_sel(setup_sel),
      .preset_sel(preset_sel), .analog_output_a(ao_a),
      .analog_output_b(ao_b), .relay_1(relay_1), .relay_2(relay_2),
      .run_cmd(run_cmd));

   rtcs_drive_model rtcs_drive_model_inst (
      .clk_sys(clk_sys), .rst(rst), .start_req(start_req),
      .ext_setup(ext_setup), .ext_preset(ext_preset),
      .di_start(di_start), .bus_start(bus_start));

   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tk

   // One APB transfer; entered just after a rising edge.
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      if (pready !== 1'b1)
      begin
         err_count++;
         give_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : xfer

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rc(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] x);
      xfer(1'b0, a, 32'h0);
      chk(q & m, x);
   endtask : rc

   task automatic do_reset();
      rst <= 1'b1;
      tk(10);
      rst <= 1'b0;
      tk(1);
   endtask : do_reset

   // Event 0 every day at 00:01 with the given ON action.
   task automatic fire(input logic [4:0] a);
      wr(12'h100, 32'h08000100 | {27'h0, a});
      wr(OFS_DATETIME, 32'h00210000);
      tk(160);
   endtask : fire

   task automatic catch_up(input logic [31:0] c, input logic [31:0] x);
      do_reset();
      wr(OFS_CTRL, c);
      wr(OFS_WEEKDAY, 32'h1);
      wr(12'h100, 32'h0800050d);
      wr(12'h104, 32'h00001e0e);
      rc(12'h104, '1, 32'h00001e0e);
      wr(OFS_DATETIME, 32'h0021000a);
      tk(12);
      rc(OFS_STATUS, 32'h80, x);
   endtask : catch_up

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      start_req = 2'h0;
      rst = 1'b1;
      err_count = 0;
      n_tests = 0;
      es = 9'h00b;
      do_reset();
      rc(OFS_DATETIME, '1, 32'h00210000);
      rc(OFS_WEEKDAY, 32'h7, 32'h1);
      rc(OFS_CTRL, 32'h3, 32'h1);
      rc(12'h1a0, '1, 32'h0);
      rc(OFS_STATUS, 32'h1e, 32'h16);
      rc(12'h0f0, '1, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(OFS_WEEKDAY, 32'h7);
      wr(OFS_DATETIME, 32'h319f173b);
      tk(160);
      rc(OFS_DATETIME, 32'hffff1f3f, 32'h32210000);
      rc(OFS_WEEKDAY, 32'h7, 32'h1);
      for (int a = 0; a < 19; a++)
      begin
         fire(a[4:0]);
         case (a)
            1, 2, 3, 4: es[1:0] = 2'(a - 1);
            5, 6, 7, 8: es[3:2] = 2'(a - 5);
            9, 10: es[4] = (a == 10);
            11, 12: es[5] = (a == 12);
            13, 14: es[6] = (a == 13);
            15, 16: es[7] = (a == 15);
            17, 18: es[8] = (a == 17);
            default: ;
         endcase
         rc(OFS_STATUS, 32'h3fe, {22'h0, es, 1'b0});
         chk(32'({relay_2, relay_1, ao_b, ao_a}), 32'(es[7:4]));
         chk(32'({preset_sel, setup_sel}), 32'(es[3:0]));
      end
      // The AND combine must hold the start until both externals agree.
      wr(OFS_CTRL, 32'h3);
      fire(5'h11);
      rc(OFS_STATUS, 32'h200, 32'h0);
      start_req <= 2'h3;
      tk(5);
      chk({31'h0, run_cmd}, 32'h1);
      wr(OFS_CTRL, 32'h1);
      fire(5'h12);
      chk({31'h0, run_cmd}, 32'h1);
      start_req <= 2'h0;
      tk(5);
      chk({31'h0, run_cmd}, 32'h0);
      wr(OFS_WEEKDAY, 32'h5);
      for (int d = 0; d < 14; d++)
      begin
         wr(12'h108, {4'h0, d[3:0], 24'h00010f});
         fire(5'h10);
         rc(OFS_STATUS, 32'h100,
            (d inside {5, 8, 9, 12, 13}) ? 32'h100 : 32'h0);
      end
      catch_up(32'h1, 32'h0);
      wr(12'h100, 32'h0800010d);
      wr(12'h104, 32'h00000211);
      wr(12'h108, 32'h0800020f);
      wr(12'h10c, 32'h00000310);
      wr(OFS_DATETIME, 32'h00210000);
      tk(160);
      rc(OFS_STATUS, 32'h380, 32'h080);
      tk(95);
      rc(OFS_STATUS, 32'h380, 32'h180);
      tk(95);
      rc(OFS_STATUS, 32'h380, 32'h080);
      catch_up(32'h0, 32'h80);
      give_verdict();
   end
endmodule : rtcs_scheduler_tb
